// ==== hw/heh_echo_taps.v ====
// Eight-tap hybrid echo filter with its coefficient register bank
`timescale 1ns/10ps
`include "heh_regs.vh"

module heh_echo_taps #(
  parameter DW   = `HEH_SMP_W,
  parameter CW   = `HEH_COEF_W,
  parameter NTAP = `HEH_NUM_TAPS,
  parameter GW   = `HEH_GUARD_W,
  parameter FRAC = `HEH_COEF_FRAC
) (
  // Clock and reset
  input  wire                     clk_sys,
  input  wire                     resetn,
  // Register port
  input  wire [`HEH_ADDR_W-1:0]   reg_addr,
  input  wire                     reg_wr_en,
  input  wire [CW-1:0]            reg_wdata,
  input  wire                     reg_rd_en,
  output reg  [CW-1:0]            reg_rdata,
  output reg                      reg_rd_valid,
  // Sample stream
  input  wire                     smp_valid,
  input  wire [DW-1:0]            tx_smp,
  input  wire [DW-1:0]            rx_smp,
  output reg  [DW-1:0]            rx_clean,
  output reg                      rx_clean_valid,
  // Status
  output reg  [NTAP-1:0]          tap_active
);

  // ========================================================================
  // Local widths
  localparam PW = DW + CW;
  localparam SW = PW + GW;

  // ========================================================================
  // Declarations
  wire [NTAP-1:0]    tap_hit;
  wire [NTAP*CW-1:0] coef_flat;
  wire [NTAP*DW-1:0] line_flat;
  wire [NTAP*PW-1:0] prod_flat;
  wire               rsvd_hit;

  reg  [CW-1:0]      rdata_d;
  reg  [SW-1:0]      acc_d;
  reg  [SW-1:0]      est_q;
  reg  [DW-1:0]      rx1_q;
  reg  [DW-1:0]      rx2_q;
  reg                v1_q;
  reg                v2_q;
  reg  [NTAP-1:0]    active_d;

  wire signed [SW-1:0] est_s;
  wire signed [SW-1:0] est_sc;
  wire signed [SW-1:0] rx_ext;
  wire signed [SW:0]   diff_s;
  reg  [DW-1:0]        clean_d;

  // Separate loop indices so no variable is shared between processes
  integer k;
  integer ka;
  integer ks;

  // ========================================================================
  // Address decode
  // Stage i sits at tap one's address plus i, so taps two to eight land
  // on consecutive addresses with no gaps.
  genvar i;
  generate
    for (i = 0; i < NTAP; i = i + 1) begin : g_tap
      localparam integer TAP_ADDR = `HEH_ADDR_TAP_ONE + i;
      wire [DW-1:0] line_in;

      // Address match per coefficient register, used for both the write strobe and the read select
      assign tap_hit[i] = (reg_addr == TAP_ADDR[`HEH_ADDR_W-1:0]);

      // First stage takes the new transmit sample, later ones the previous
      if (i == 0) begin : g_first
        assign line_in = tx_smp;
      end else begin : g_next
        assign line_in = line_flat[(i-1)*DW +: DW];
      end

      heh_tap #(
        .DW (DW),
        .CW (CW)
      ) u_tap (
        .clk_sys    (clk_sys),
        .resetn     (resetn),
        .coef_we    (reg_wr_en & tap_hit[i]),
        .coef_wdata (reg_wdata),
        .shift_en   (smp_valid),
        .smp_in     (line_in),
        .smp_q      (line_flat[i*DW +: DW]),
        .coef_q     (coef_flat[i*CW +: CW]),
        .prod       (prod_flat[i*PW +: PW])
      );
    end
  endgenerate

  // Reserved window; writes here change nothing inside the block
  assign rsvd_hit = (reg_addr >= `HEH_ADDR_RSVD_FIRST) &&
                    (reg_addr <= `HEH_ADDR_RSVD_LAST);

  // ========================================================================
  // Read path
  // Reserved and unmapped addresses read back as zero; software is told
  // not to trust the reserved range, so zero is as good as any value.
  always @* begin
    rdata_d = `HEH_RD_IDLE;
    for (k = 0; k < NTAP; k = k + 1) begin
      if (tap_hit[k]) begin
        rdata_d = coef_flat[k*CW +: CW];
      end
    end
    if (rsvd_hit) begin
      rdata_d = `HEH_RD_IDLE;
    end
  end

  // Read data held until the next read
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata    <= `HEH_RD_IDLE;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata <= rdata_d;
      end
    end
  end

  // ========================================================================
  // Tap status
  // One bit per stage that currently shapes the response
  always @* begin
    for (ka = 0; ka < NTAP; ka = ka + 1) begin
      active_d[ka] = (coef_flat[ka*CW +: CW] != `HEH_COEF_RST);
    end
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tap_active <= {NTAP{1'b0}};
    end else begin
      tap_active <= active_d;
    end
  end

  // ========================================================================
  // Echo estimate
  // Guard bits let all eight full-scale products add without wrapping.
  always @* begin
    acc_d = {SW{1'b0}};
    for (ks = 0; ks < NTAP; ks = ks + 1) begin
      acc_d = acc_d + {{GW{prod_flat[ks*PW+PW-1]}}, prod_flat[ks*PW +: PW]};
    end
  end

  // Two-stage pipeline: sum, then subtract; receive sample rides alongside
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      v1_q  <= 1'b0;
      v2_q  <= 1'b0;
      rx1_q <= {DW{1'b0}};
      rx2_q <= {DW{1'b0}};
      est_q <= {SW{1'b0}};
    end else begin
      v1_q <= smp_valid;
      v2_q <= v1_q;
      if (smp_valid) begin
        rx1_q <= rx_smp;
      end
      if (v1_q) begin
        est_q <= acc_d;
        rx2_q <= rx1_q;
      end
    end
  end

  // ========================================================================
  // Cancellation
  // Coefficients are signed with FRAC fraction bits; estimate is rescaled.
  assign est_s  = est_q;
  assign est_sc = est_s >>> FRAC;
  assign rx_ext = {{(SW-DW){rx2_q[DW-1]}}, rx2_q};
  assign diff_s = {rx_ext[SW-1], rx_ext} - {est_sc[SW-1], est_sc};

  // Saturate so a badly tuned filter clips instead of wrapping
  always @* begin
    if ((diff_s[SW:DW-1] != {(SW-DW+2){1'b0}}) &&
        (diff_s[SW:DW-1] != {(SW-DW+2){1'b1}})) begin
      clean_d = diff_s[SW] ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};
    end else begin
      clean_d = diff_s[DW-1:0];
    end
  end

  // Cleaned receive sample, held until the next one
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_clean       <= {DW{1'b0}};
      rx_clean_valid <= 1'b0;
    end else begin
      rx_clean_valid <= v2_q;
      if (v2_q) begin
        rx_clean <= clean_d;
      end
    end
  end

endmodule // heh_echo_taps

// ==== hw/heh_regs.vh ====
// Register map and constants for the hybrid echo tap register bank
`ifndef HEH_REGS_VH
`define HEH_REGS_VH

// ==========================================================================
// Register addresses
`define HEH_ADDR_W          8
`define HEH_ADDR_TAP_ONE    8'h2d
`define HEH_ADDR_TAP_TWO    8'h2e
`define HEH_ADDR_TAP_THREE  8'h2f
`define HEH_ADDR_TAP_FOUR   8'h30
`define HEH_ADDR_TAP_FIVE   8'h31
`define HEH_ADDR_TAP_SIX    8'h32
`define HEH_ADDR_TAP_SEVEN  8'h33
`define HEH_ADDR_TAP_EIGHT  8'h34
`define HEH_ADDR_RSVD_FIRST 8'h35
`define HEH_ADDR_RSVD_LAST  8'h3a

// ==========================================================================
// Field layout and reset values
`define HEH_COEF_W          8
`define HEH_COEF_RST        8'h00
`define HEH_RD_IDLE         8'h00
`define HEH_NUM_TAPS        8
`define HEH_GUARD_W         3
`define HEH_COEF_FRAC       7
`define HEH_SMP_W           16

`endif

// ==== hw/heh_tap.v ====
// One filter stage: coefficient register, delay-line sample and its product
`timescale 1ns/10ps
`include "heh_regs.vh"

module heh_tap #(
  parameter DW = 16,
  parameter CW = 8
) (
  // Clock and reset
  input  wire                 clk_sys,
  input  wire                 resetn,
  // Coefficient write
  input  wire                 coef_we,
  input  wire [CW-1:0]        coef_wdata,
  // Delay line
  input  wire                 shift_en,
  input  wire [DW-1:0]        smp_in,
  output reg  [DW-1:0]        smp_q,
  // Stage results
  output reg  [CW-1:0]        coef_q,
  output wire [DW+CW-1:0]     prod
);

  // ========================================================================
  // Storage
  wire signed [DW-1:0]    smp_s;
  wire signed [CW-1:0]    coef_s;
  wire signed [DW+CW-1:0] mul_s;

  // Coefficient and sample hold, both cleared so a fresh stage is silent
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      coef_q <= `HEH_COEF_RST;
      smp_q  <= {DW{1'b0}};
    end else begin
      if (coef_we) begin
        coef_q <= coef_wdata;
      end
      if (shift_en) begin
        smp_q <= smp_in;
      end
    end
  end

  // ========================================================================
  // Product
  assign smp_s  = smp_q;
  assign coef_s = coef_q;
  assign mul_s  = smp_s * coef_s;

  // Forced to zero, not merely multiplied by zero, so intent is explicit
  assign prod = (coef_q == `HEH_COEF_RST) ? {(DW+CW){1'b0}} : mul_s;

endmodule // heh_tap

// ==== test/heh_echo_taps_monitor.sv ====
// Port checker for the hybrid echo tap register bank
`timescale 1ns/10ps
module heh_echo_taps_monitor (
  // Clock and reset
  input wire        clk_sys,
  input wire        resetn,
  // Register writes
  input wire [7:0]  reg_addr,
  input wire        reg_wr_en,
  input wire [7:0]  reg_wdata,
  // Samples and status
  input wire        smp_valid,
  input wire [15:0] rx_smp,
  input wire [15:0] rx_clean,
  input wire        rx_clean_valid,
  input wire [7:0]  tap_active
);
  // ==========================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Status bit lags its coefficient by one edge, so two edges after the write
  property p_act(a, i);
    reg_wr_en && reg_addr == a |=> ##1 tap_active[i] == |$past(reg_wdata, 2);
  endproperty
  a_tap_two_act:
    assert property (p_act(8'h2e, 1)) else $error("tap two status");
  a_tap_five_act:
    assert property (p_act(8'h31, 4)) else $error("tap five status");
  a_tap_six_act:
    assert property (p_act(8'h32, 5)) else $error("tap six status");
  a_tap_seven_act:
    assert property (p_act(8'h33, 6)) else $error("tap seven status");
  a_tap_eight_act:
    assert property (p_act(8'h34, 7)) else $error("tap eight status");
  // Zero coefficients leave the receive path untouched
  a_zero_pass:
    assert property (smp_valid && tap_active == 8'h00 && !reg_wr_en && !$past(reg_wr_en)
      |-> ##3 rx_clean == $past(rx_smp, 3)) else $error("zero taps alter rx");
  a_clean_lat:
    assert property (smp_valid |-> ##3 rx_clean_valid) else $error("result latency");
  a_reset_clear:
    assert property ($rose(resetn) |-> tap_active == 8'h00) else $error("reset status");
  cover property (reg_wr_en && reg_addr == 8'h34);
  cover property (rx_clean_valid && tap_active != 8'h00);
  cover property ($rose(resetn));
endmodule // heh_echo_taps_monitor

bind heh_echo_taps heh_echo_taps_monitor u_heh_echo_taps_monitor (
  .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
  .reg_wdata(reg_wdata), .smp_valid(smp_valid), .rx_smp(rx_smp), .rx_clean(rx_clean),
  .rx_clean_valid(rx_clean_valid), .tap_active(tap_active));

// ==== test/heh_echo_taps_tb.sv ====
// Self-checking bench for the hybrid echo tap register bank
`timescale 1ns/10ps
module heh_echo_taps_tb;
  reg         clk_sys = 1'b0;
  reg         resetn = 1'b0;
  reg         smp_valid = 1'b0;
  reg  [15:0] tx_smp = 16'h0000;
  reg  [15:0] rx_smp = 16'h0000;
  wire [7:0]  reg_addr, reg_wdata, reg_rdata, tap_active;
  wire        reg_wr_en, reg_rd_en, reg_rd_valid, rx_clean_valid;
  wire [15:0] rx_clean;
  reg  [8:0]  q;
  integer     num_errors = 0;
  integer     tests_run = 0;
  integer     k, n;
  always #5 clk_sys = ~clk_sys;
  // ==========================================
  // Device and host
  heh_echo_taps u_heh_echo_taps (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .smp_valid(smp_valid),
    .tx_smp(tx_smp), .rx_smp(rx_smp), .rx_clean(rx_clean),
    .rx_clean_valid(rx_clean_valid), .tap_active(tap_active));
  heh_host_model u_heh_host_model (.clk_sys(clk_sys), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));
  // Compare and count
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // One sample; result is launched two edges after the taking edge, looked at after that
  task smp(input [15:0] t, input [15:0] e);
    begin
      @(negedge clk_sys);
      tx_smp = t;
      rx_smp = 16'h1000;
      smp_valid = 1'b1;
      @(negedge clk_sys);
      smp_valid = 1'b0;
      tx_smp = ~t;
      rx_smp = 16'hefff;
      @(negedge clk_sys);
      @(negedge clk_sys);
      chk("clean_valid", 16'h0001, {15'h0000, rx_clean_valid});
      chk("rx_clean", e, rx_clean);
    end
  endtask
  task give_verdict;
    begin
      $display("errors %0d comparisons %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #20000;
    num_errors = num_errors + 1;
    give_verdict;
  end
  // Main sequence
  initial begin
    repeat (8) @(negedge clk_sys);
    resetn = 1'b1;
    // Reset values; reserved and unmapped places read zero
    for (k = 8'h2c; k <= 8'h3b; k = k + 1) begin
      u_heh_host_model.rd(k[7:0], q);
      chk("reset_read", 16'h0100, {7'h00, q});
    end
    // Zero taps pass rx through; the trailing zeros walk the impulse down to the last stage
    for (n = 0; n < 8; n = n + 1)
      smp((n == 0) ? 16'h7fff : 16'h0000, 16'h1000);
    // Distinct values in every tap, taps two to eight read back one after another
    for (k = 0; k < 8; k = k + 1)
      u_heh_host_model.wr(8'h2d + k[7:0], 8'h81 + k[7:0]);
    for (k = 1; k < 8; k = k + 1) begin
      u_heh_host_model.rd(8'h2d + k[7:0], q);
      chk("readback", {8'h01, 8'h81 + k[7:0]}, {7'h00, q});
    end
    for (k = 0; k < 8; k = k + 1)
      u_heh_host_model.wr(8'h2d + k[7:0], 8'h00);
    // Half-weight tap k alone: impulse echo of 0x80 shows after k samples
    for (k = 1; k < 8; k = k + 1) begin
      u_heh_host_model.wr(8'h2d + k[7:0], 8'h40);
      for (n = 0; n < 8; n = n + 1)
        smp((n == 0) ? 16'h0100 : 16'h0000, (n == k) ? 16'h0f80 : 16'h1000);
      u_heh_host_model.wr(8'h2d + k[7:0], 8'h00);
    end
    // Second reset in mid-run clears a programmed tap
    u_heh_host_model.wr(8'h34, 8'h55);
    resetn = 1'b0;
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
    u_heh_host_model.rd(8'h34, q);
    chk("rereset", 16'h0100, {7'h00, q});
    give_verdict;
  end
endmodule // heh_echo_taps_tb

// ==== test/heh_host_model.sv ====
// Host model driving the register port of the tap bank
`timescale 1ns/10ps
module heh_host_model (
  // Clock
  input  wire       clk_sys,
  // Register port
  output reg  [7:0] reg_addr,
  output reg        reg_wr_en,
  output reg  [7:0] reg_wdata,
  output reg        reg_rd_en,
  input  wire [7:0] reg_rdata,
  input  wire       reg_rd_valid
);
  // ==========================================
  // Idle port at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_en = 1'b0;
  end
  // One-cycle write; reserved places are skipped, their contents undefined
  task wr(input [7:0] a, input [7:0] d);
    begin
      if (a < 8'h35 || a > 8'h3a) begin
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge clk_sys);
        reg_wr_en = 1'b0;
        reg_wdata = ~d;
      end
    end
  endtask
  // Answer sampled the cycle after the strobe edge, valid flag included
  task rd(input [7:0] a, output [8:0] q);
    begin
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd_en = 1'b1;
      @(negedge clk_sys);
      reg_rd_en = 1'b0;
      q = {reg_rd_valid, reg_rdata};
    end
  endtask
endmodule // heh_host_model
